// ===== tb/qsfpi_host_model.sv
// host serial controller model: clock, select, lines 0 and 1
`timescale 1ns/10ps
module qsfpi_host_model (
    input wire logic clock,
    input wire logic sampleLine,
    output logic spiClock,
    output logic chipSelect_n,
    output logic [1:0] hostLines
);
    // idle with clock low and device deselected
    initial begin
        spiClock = 1'b0;
        chipSelect_n = 1'b1;
        hostLines = 2'h0;
    end
    // select edge opens or closes a frame, held across holds
    task automatic frame(input logic sel);
        @(posedge clock) #1 chipSelect_n = ~sel;
        repeat (4) @(posedge clock);
        #1;
    endtask
    // msb first on line 0 while clock low, line 1 taken at rise
    task automatic xfer(input logic [7:0] out, input int n, output logic [7:0] in);
        for (int i = 0; i < n; i++) begin
            hostLines = {~hostLines[1], out[7]};
            out = out << 1;
            repeat (4) @(posedge clock);
            #1 spiClock = 1'b1;
            in = {in[6:0], sampleLine};
            repeat (4) @(posedge clock);
            #1 spiClock = 1'b0;
        end
    endtask
endmodule

// ===== tb/tb_top.sv
// self-checking bench of the flash pin interface
`timescale 1ns/10ps
module tb_top;
    logic clock = 1'b0, reset = 1'b1, quadEnableBit = 1'b0, txEnable = 1'b0, rxReady = 1'b1;
    logic opStart = 1'b0, opDone = 1'b0, wpPin = 1'b1, holdPin = 1'b1, checkRx = 1'b1;
    logic spiClock, chipSelect_n, rxFirst, rxValid, rxOverrun, quadRefused, cycleBusy, holdActive;
    logic statusWriteOk, addrProtected, txReady, selected, topBottomSelectBit = 1'b0, sectorGranularityBit = 1'b0;
    logic executeInPlace = 1'b0, pageLoad = 1'b0;
    logic [1:0] hostLines, rxLanes = 2'h0, txLanes = 2'h0;
    logic [2:0] protectRangeBits = 3'h0;
    logic [3:0] dataLineIn, dataLineOut, dataLineOe;
    logic [7:0] txData = 8'h0, rxData, op, rd, pageRdData, pageRdAddr = 8'h0;
    logic [20:0] checkAddr = 21'h0, eraseBase;
    logic [63:0] uniqueId;
    qsfpi_pkg::qsfpi_erase_t eraseKind = qsfpi_pkg::ERASE_SECTOR;
    logic [8:0] expQ[$];
    int errCount = 0, comparisons = 0, txTaken = 0, span;
    int lg[4] = '{12, 15, 16, 21};
    always #4 clock = ~clock;
    // wire level: device lane when enabled, else host or pin level
    assign dataLineIn = (dataLineOe & dataLineOut) | (~dataLineOe & {holdPin, wpPin, hostLines});
    qsfpi_pin_interface uut (.clock, .reset, .spiClock, .chipSelect_n, .dataLineIn, .dataLineOut, .dataLineOe,
        .quadEnableBit, .protectRangeBits, .topBottomSelectBit, .sectorGranularityBit,
        .executeInPlace, .rxLanes, .txLanes, .txEnable, .txData, .txReady, .rxData, .rxFirst,
        .rxValid, .rxReady, .rxOverrun, .quadRefused, .opStart, .opDone, .cycleBusy, .selected,
        .holdActive, .statusWriteOk, .checkAddr, .eraseKind, .addrProtected, .eraseBase, .pageLoad,
        .pageRdAddr, .pageRdData, .uniqueId);
    qsfpi_host_model host (.clock, .sampleLine(dataLineIn[1]), .spiClock, .chipSelect_n, .hostLines);
    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        comparisons++;
        if (g !== e) begin
            errCount++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wrapUp;
        $display("counts: %0d compared, %0d mismatched", comparisons, errCount);
        if (errCount == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // note the expected byte, then clock it in
    task automatic rxByte(input logic first, input logic [7:0] b);
        expQ.push_back({first, b});
        host.xfer(b, 8, rd);
    endtask
    // bounded wait until every noted byte has come out
    task automatic drain;
        repeat (6) @(posedge clock);
        for (int i = 0; i < 400 && expQ.size() != 0; i++) @(posedge clock);
        #1 chk("queue left", 64'h0, 64'(expQ.size()));
        if (expQ.size() != 0) wrapUp();
    endtask
    // oldest note against each byte the fifo hands over
    always @(posedge clock) begin
        if (checkRx && rxValid === 1'b1 && rxReady === 1'b1) begin
            chk("rx byte", expQ.size() != 0 ? 64'(expQ.pop_front()) : 64'h1_0000, {rxFirst, rxData});
        end
        if (txReady === 1'b1) txTaken++; // one per byte taken for sending
    end
    initial begin
        void'($urandom(32'h1803));
        repeat (20) @(posedge clock);
        #1 reset = 1'b0;
        host.xfer(8'ha5, 8, rd);
        chk("oe idle", 4'h0, dataLineOe);
        chk("unique id", qsfpi_pkg::UID_DEFAULT, uniqueId);
        chk("status ok", 1'b1, statusWriteOk);
        wpPin = 1'b0;
        repeat (6) @(posedge clock);
        #1 chk("status ok", 1'b0, statusWriteOk);
        quadEnableBit = 1'b1;
        repeat (6) @(posedge clock);
        #1 chk("status ok", 1'b1, statusWriteOk);
        quadEnableBit = 1'b0;
        wpPin = 1'b1;
        $display("test pins done");
        op = 8'($urandom);
        txData = 8'($urandom);
        pageLoad = 1'b1;
        host.frame(1'b1);
        chk("selected", 1'b1, selected);
        rxByte(1'b1, op);
        rxByte(1'b0, txData);
        rxByte(1'b0, ~txData);
        drain();
        pageRdAddr = 8'h1;
        repeat (2) @(posedge clock);
        #1 chk("page byte", 8'(~txData), pageRdData);
        pageRdAddr = 8'h0;
        pageLoad = 1'b0;
        repeat (2) @(posedge clock);
        #1 chk("page byte", txData, pageRdData);
        txData = 8'($urandom);
        txEnable = 1'b1;
        host.xfer(8'h0, 9, rd);
        chk("read byte", txData, rd);
        chk("oe single", 4'h2, dataLineOe);
        opStart = 1'b1;
        @(posedge clock) #1 opStart = 1'b0;
        host.frame(1'b0);
        txEnable = 1'b0;
        drain();
        chk("oe off", 4'h0, dataLineOe);
        chk("selected", 1'b0, selected);
        chk("tx taken", 64'h2, 64'(txTaken));
        chk("busy", 1'b1, cycleBusy);
        opDone = 1'b1;
        @(posedge clock) #1 opDone = 1'b0;
        @(posedge clock) #1 chk("busy", 1'b0, cycleBusy);
        $display("test frame done");
        rxLanes = qsfpi_pkg::LANE_4;
        host.frame(1'b1);
        rxByte(1'b1, op);
        rxByte(1'b0, 8'($urandom));
        chk("quad refused", 1'b1, quadRefused);
        host.frame(1'b0);
        rxLanes = qsfpi_pkg::LANE_1;
        drain();
        quadEnableBit = 1'b1;
        for (int k = 1; k < 3; k++) begin
            txLanes = 2'(k);
            txData = 8'($urandom);
            host.frame(1'b1);
            txEnable = 1'b1;
            host.xfer(8'h0, 1, rd);
            repeat (4) @(posedge clock);
            #1 chk("wide out", k == 1 ? {4'h3, 2'h0, txData[7:6]} : {4'hf, txData[7:4]},
                {dataLineOe, dataLineOut});
            host.frame(1'b0);
            txEnable = 1'b0;
        end
        quadEnableBit = 1'b0;
        txLanes = qsfpi_pkg::LANE_1;
        chk("tx taken", 64'h4, 64'(txTaken));
        $display("test quad done");
        host.frame(1'b1);
        expQ.push_back({1'b1, op});
        host.xfer(op, 4, rd);
        holdPin = 1'b0;
        repeat (6) @(posedge clock);
        #1 chk("hold", 1'b1, holdActive);
        host.xfer(8'hff, 3, rd);
        holdPin = 1'b1;
        repeat (6) @(posedge clock);
        #1 host.xfer(op << 4, 4, rd);
        host.frame(1'b0);
        drain();
        executeInPlace = 1'b1;
        host.frame(1'b1);
        rxByte(1'b0, op);
        host.frame(1'b0);
        executeInPlace = 1'b0;
        drain();
        $display("test hold done");
        rxReady = 1'b0;
        checkRx = 1'b0;
        host.frame(1'b1);
        for (int i = 0; i < 20; i++) host.xfer(8'($urandom), 8, rd);
        host.frame(1'b0);
        chk("overrun", 1'b1, rxOverrun);
        rxReady = 1'b1;
        for (int i = 0; i < 60 && rxValid !== 1'b0; i++) @(posedge clock);
        #1 chk("drained", 1'b0, rxValid);
        checkRx = 1'b1;
        $display("test fifo done");
        for (int k = 0; k < 8; k++) begin
            eraseKind = qsfpi_pkg::qsfpi_erase_t'(k % 4);
            checkAddr = 21'($urandom);
            protectRangeBits = 3'($urandom);
            {topBottomSelectBit, sectorGranularityBit} = 2'($urandom);
            span = (sectorGranularityBit ? 32'h1000 : 32'h1_0000) << protectRangeBits >> 1;
            repeat (3) @(posedge clock);
            #1 chk("erase base", checkAddr & ~((21'h1 << lg[k % 4]) - 21'h1), eraseBase);
            chk("protected", protectRangeBits == 3'h0 ? 1'b0 : span >= 32'h20_0000 ? 1'b1 : topBottomSelectBit ?
                checkAddr < span : checkAddr >= 32'h20_0000 - span, addrProtected);
        end
        $display("test erase done");
        wrapUp();
    end
endmodule

// ===== verilog/qsfpi_fifo.sv
// received byte fifo with registered output stage
`timescale 1ns/10ps
module qsfpi_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    input wire logic clock,
    input wire logic reset,
    qsfpi_stream_if.snk inPort,
    qsfpi_stream_if.src outPort
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] store [DEPTH];
    logic [AW-1:0] wrPtr, next_wrPtr, rdPtr, next_rdPtr;
    logic [AW:0] count, next_count;
    logic outValid, next_outValid;
    logic [WIDTH-1:0] outData, next_outData;
    logic push, pop;

    assign inPort.ready = (count != (AW + 1)'(DEPTH));
    assign outPort.valid = outValid;
    assign outPort.data = outData;
    assign push = inPort.valid && inPort.ready;
    assign pop = (count != '0) && (!outValid || outPort.ready);

    // pointer, count and output stage
    always_comb begin
        next_wrPtr = push ? wrPtr + 1'b1 : wrPtr;
        next_rdPtr = pop ? rdPtr + 1'b1 : rdPtr;
        next_count = count + (AW + 1)'(push) - (AW + 1)'(pop);
        next_outValid = outValid;
        next_outData = outData;
        if (pop) begin
            next_outValid = 1'b1;
            next_outData = store[rdPtr];
        end else if (outPort.ready) begin
            next_outValid = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
            outValid <= 1'b0;
            outData <= '0;
        end else begin
            wrPtr <= next_wrPtr;
            rdPtr <= next_rdPtr;
            count <= next_count;
            outValid <= next_outValid;
            outData <= next_outData;
        end
    end

    // storage array, no reset needed
    always_ff @(posedge clock) begin
        if (push) begin
            store[wrPtr] <= inPort.data;
        end
    end
endmodule

// ===== verilog/qsfpi_page_mem.sv
// page buffer memory with registered read data
`timescale 1ns/10ps
module qsfpi_page_mem #(
    parameter int AW = 8,
    parameter int DW = 8
) (
    input wire logic clock,
    input wire logic writeEn,
    input wire logic [AW-1:0] writeAddr,
    input wire logic [DW-1:0] writeData,
    input wire logic [AW-1:0] readAddr,
    output logic [DW-1:0] readData
);
    logic [DW-1:0] store [1 << AW];

    // write port and registered read port
    always_ff @(posedge clock) begin
        if (writeEn) begin
            store[writeAddr] <= writeData;
        end
        readData <= store[readAddr];
    end
endmodule

// ===== verilog/qsfpi_pin_interface.sv
// pin-level serial interface of a quad serial flash device
`timescale 1ns/10ps
module qsfpi_pin_interface #(
    parameter int FIFO_DEPTH = qsfpi_pkg::FIFO_DEPTH,
    parameter logic [63:0] UNIQUE_ID = qsfpi_pkg::UID_DEFAULT
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic spiClock,
    input wire logic chipSelect_n,
    input wire logic [qsfpi_pkg::LANES-1:0] dataLineIn,
    output logic [qsfpi_pkg::LANES-1:0] dataLineOut,
    output logic [qsfpi_pkg::LANES-1:0] dataLineOe,
    input wire logic quadEnableBit,
    input wire logic [2:0] protectRangeBits,
    input wire logic topBottomSelectBit,
    input wire logic sectorGranularityBit,
    input wire logic executeInPlace,
    input wire logic [1:0] rxLanes,
    input wire logic [1:0] txLanes,
    input wire logic txEnable,
    input wire logic [qsfpi_pkg::BYTE_W-1:0] txData,
    output logic txReady,
    output logic [qsfpi_pkg::BYTE_W-1:0] rxData,
    output logic rxFirst,
    output logic rxValid,
    input wire logic rxReady,
    output logic rxOverrun,
    output logic quadRefused,
    input wire logic opStart,
    input wire logic opDone,
    output logic cycleBusy,
    output logic selected,
    output logic holdActive,
    output logic statusWriteOk,
    input wire logic [qsfpi_pkg::ADDR_W-1:0] checkAddr,
    input wire qsfpi_pkg::qsfpi_erase_t eraseKind,
    output logic addrProtected,
    output logic [qsfpi_pkg::ADDR_W-1:0] eraseBase,
    input wire logic pageLoad,
    input wire logic [qsfpi_pkg::PAGE_LOG-1:0] pageRdAddr,
    output logic [qsfpi_pkg::BYTE_W-1:0] pageRdData,
    output logic [63:0] uniqueId
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [3:0] laneStep(input logic [1:0] lanes);
        laneStep = (lanes == qsfpi_pkg::LANE_4) ? 4'h4 : (lanes == qsfpi_pkg::LANE_2) ? 4'h2 : 4'h1;
    endfunction

    function automatic logic [3:0] laneMask(input logic [1:0] lanes);
        laneMask = (lanes == qsfpi_pkg::LANE_4) ? 4'hf : (lanes == qsfpi_pkg::LANE_2) ? 4'h3 : 4'h2;
    endfunction

    // protected range: top or bottom, 4 KB or 64 KB units doubling per step
    function automatic logic rangeHit(input logic [qsfpi_pkg::ADDR_W-1:0] addr, input logic [2:0] bp,
                                      input logic tb, input logic sec);
        logic [4:0] lg;
        logic [qsfpi_pkg::ADDR_W:0] span;
        lg = (sec ? qsfpi_pkg::SECTOR_LOG : qsfpi_pkg::BLK64_LOG) + {2'h0, bp} - 5'h1;
        span = (qsfpi_pkg::ADDR_W + 1)'(1) << lg;
        if (bp == qsfpi_pkg::BP_NONE) begin
            rangeHit = 1'b0;
        end else if (span >= qsfpi_pkg::ARRAY_SPAN) begin
            rangeHit = 1'b1;
        end else if (tb) begin
            rangeHit = {1'b0, addr} < span;
        end else begin
            rangeHit = {1'b0, addr} >= qsfpi_pkg::ARRAY_SPAN - span;
        end
    endfunction

    // erase base alignment per unit
    function automatic logic [qsfpi_pkg::ADDR_W-1:0] eraseAlign(input logic [qsfpi_pkg::ADDR_W-1:0] addr,
                                                                 input qsfpi_pkg::qsfpi_erase_t kind);
        int unsigned pages;
        case (kind)
            qsfpi_pkg::ERASE_SECTOR: pages = qsfpi_pkg::SECTOR_PAGES;
            qsfpi_pkg::ERASE_BLK32: pages = qsfpi_pkg::BLK32_PAGES;
            qsfpi_pkg::ERASE_BLK64: pages = qsfpi_pkg::BLK64_PAGES;
            default: pages = qsfpi_pkg::PAGE_COUNT;
        endcase
        eraseAlign = addr & ~qsfpi_pkg::ADDR_W'(pages * qsfpi_pkg::PAGE_BYTES - 1);
    endfunction

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] sclkPipe, csPipe;
    logic [qsfpi_pkg::LANES-1:0] dataMeta, dataLevel;
    logic sclkRise, sclkFall, csHigh, csFall;

    // two flops per pin, third stage only for edge finding
    always_ff @(posedge clock) begin
        if (reset) begin
            sclkPipe <= 3'h0;
            csPipe <= 3'h7;
            dataMeta <= 4'hf;
            dataLevel <= 4'hf;
        end else begin
            sclkPipe <= {sclkPipe[1:0], spiClock};
            csPipe <= {csPipe[1:0], chipSelect_n};
            dataMeta <= dataLineIn;
            dataLevel <= dataMeta;
        end
    end

    assign sclkRise = sclkPipe[1] && !sclkPipe[2];
    assign sclkFall = !sclkPipe[1] && sclkPipe[2];
    assign csHigh = csPipe[1];
    assign csFall = !csPipe[1] && csPipe[2];

    // ------------------------------------------------------------
    // received byte fifo and page buffer
    // ------------------------------------------------------------
    qsfpi_stream_if #(.W(qsfpi_pkg::BYTE_W + 1)) rxIn();
    qsfpi_stream_if #(.W(qsfpi_pkg::BYTE_W + 1)) rxOut();

    logic pushValid, next_pushValid;
    logic [qsfpi_pkg::BYTE_W:0] pushData, next_pushData;
    logic [qsfpi_pkg::PAGE_LOG-1:0] pageCol, next_pageCol;
    logic memWe;

    assign rxIn.valid = pushValid;
    assign rxIn.data = pushData;
    assign rxOut.ready = rxReady;
    assign rxValid = rxOut.valid;
    assign rxData = rxOut.data[qsfpi_pkg::BYTE_W-1:0];
    assign rxFirst = rxOut.data[qsfpi_pkg::BYTE_W];
    assign memWe = pushValid && !pushData[qsfpi_pkg::BYTE_W] && pageLoad;

    qsfpi_fifo #(.WIDTH(qsfpi_pkg::BYTE_W + 1), .DEPTH(FIFO_DEPTH)) rxFifo (
        .clock(clock),
        .reset(reset),
        .inPort(rxIn),
        .outPort(rxOut)
    );

    qsfpi_page_mem #(.AW(qsfpi_pkg::PAGE_LOG), .DW(qsfpi_pkg::BYTE_W)) pageBuffer (
        .clock(clock),
        .writeEn(memWe),
        .writeAddr(pageCol),
        .writeData(pushData[qsfpi_pkg::BYTE_W-1:0]),
        .readAddr(pageRdAddr),
        .readData(pageRdData)
    );

    // ------------------------------------------------------------
    // serial engine
    // ------------------------------------------------------------
    logic armed, next_armed, instrPhase, next_instrPhase, next_holdActive;
    logic [3:0] bitCnt, next_bitCnt, txBits, next_txBits, cntSum, txStep;
    logic [7:0] shiftIn, next_shiftIn, txShift, next_txShift, curShift;
    logic [1:0] effRx, effTx;
    logic quadAsk, next_txReady, next_rxOverrun, next_quadRefused, next_cycleBusy;
    logic [qsfpi_pkg::LANES-1:0] next_dataLineOut, next_dataLineOe;

    // next state of the transfer
    always_comb begin
        quadAsk = (rxLanes == qsfpi_pkg::LANE_4 || txLanes == qsfpi_pkg::LANE_4) && !quadEnableBit;
        effRx = (instrPhase || (rxLanes == qsfpi_pkg::LANE_4 && !quadEnableBit)) ? qsfpi_pkg::LANE_1 : rxLanes;
        effTx = (txLanes == qsfpi_pkg::LANE_4 && !quadEnableBit) ? qsfpi_pkg::LANE_1 : txLanes;
        cntSum = bitCnt + laneStep(effRx);
        txStep = laneStep(effTx);
        curShift = (txBits == 4'h0) ? txData : txShift;
        next_armed = armed || csFall;
        next_instrPhase = instrPhase;
        next_holdActive = holdActive;
        next_bitCnt = bitCnt;
        next_shiftIn = shiftIn;
        next_txBits = txBits;
        next_txShift = txShift;
        next_txReady = 1'b0;
        next_pushValid = 1'b0;
        next_pushData = pushData;
        next_pageCol = memWe ? pageCol + 1'b1 : pageCol;
        next_dataLineOut = dataLineOut;
        next_cycleBusy = opStart ? 1'b1 : opDone ? 1'b0 : cycleBusy;
        next_rxOverrun = (pushValid && !rxIn.ready) ? 1'b1 : csFall ? 1'b0 : rxOverrun;
        next_quadRefused = (quadAsk && !csHigh) ? 1'b1 : csFall ? 1'b0 : quadRefused;
        if (csFall) begin
            next_pageCol = '0;
        end
        if (csHigh) begin
            // deselect clears transfer state, also ends a hold
            next_holdActive = 1'b0;
            next_instrPhase = !executeInPlace;
            next_bitCnt = 4'h0;
            next_txBits = 4'h0;
        end else begin
            if (quadEnableBit) begin
                next_holdActive = 1'b0;
            end else if (!sclkPipe[1]) begin
                next_holdActive = !dataLevel[3];
            end
            // paused state is simply left untouched while holding
            if (armed && !holdActive) begin
                if (sclkRise && !txEnable) begin
                    case (effRx)
                        qsfpi_pkg::LANE_4: next_shiftIn = {shiftIn[3:0], dataLevel};
                        qsfpi_pkg::LANE_2: next_shiftIn = {shiftIn[5:0], dataLevel[1:0]};
                        default: next_shiftIn = {shiftIn[6:0], dataLevel[0]};
                    endcase
                    next_bitCnt = cntSum;
                    if (cntSum == qsfpi_pkg::BYTE_BITS) begin
                        next_bitCnt = 4'h0;
                        next_pushValid = 1'b1;
                        next_pushData = {instrPhase, next_shiftIn};
                        next_instrPhase = 1'b0;
                    end
                end
                if (sclkFall && txEnable) begin
                    next_txReady = (txBits == 4'h0);
                    case (effTx)
                        qsfpi_pkg::LANE_4: next_dataLineOut = curShift[7:4];
                        qsfpi_pkg::LANE_2: next_dataLineOut = {dataLineOut[3:2], curShift[7:6]};
                        default: next_dataLineOut = {dataLineOut[3:2], curShift[7], dataLineOut[0]};
                    endcase
                    next_txShift = curShift << txStep;
                    next_txBits = ((txBits == 4'h0) ? qsfpi_pkg::BYTE_BITS : txBits) - txStep;
                end
            end
        end
        // lines driven only while selected, not holding and sending
        next_dataLineOe = (!csHigh && !holdActive && armed && txEnable) ? laneMask(effTx) : 4'h0;
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            armed <= 1'b0;
            instrPhase <= 1'b1;
            holdActive <= 1'b0;
            bitCnt <= 4'h0;
            shiftIn <= 8'h00;
            txBits <= 4'h0;
            txShift <= 8'h00;
            txReady <= 1'b0;
            pushValid <= 1'b0;
            pushData <= '0;
            pageCol <= '0;
            dataLineOut <= 4'h0;
            dataLineOe <= 4'h0;
            cycleBusy <= 1'b0;
            rxOverrun <= 1'b0;
            quadRefused <= 1'b0;
        end else begin
            armed <= next_armed;
            instrPhase <= next_instrPhase;
            holdActive <= next_holdActive;
            bitCnt <= next_bitCnt;
            shiftIn <= next_shiftIn;
            txBits <= next_txBits;
            txShift <= next_txShift;
            txReady <= next_txReady;
            pushValid <= next_pushValid;
            pushData <= next_pushData;
            pageCol <= next_pageCol;
            dataLineOut <= next_dataLineOut;
            dataLineOe <= next_dataLineOe;
            cycleBusy <= next_cycleBusy;
            rxOverrun <= next_rxOverrun;
            quadRefused <= next_quadRefused;
        end
    end

    // ------------------------------------------------------------
    // protection and status outputs
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (reset) begin
            selected <= 1'b0;
            statusWriteOk <= 1'b0;
            addrProtected <= 1'b0;
            eraseBase <= '0;
            uniqueId <= 64'h0;
        end else begin
            selected <= !csHigh;
            statusWriteOk <= dataLevel[2] || quadEnableBit;
            addrProtected <= rangeHit(checkAddr, protectRangeBits, topBottomSelectBit, sectorGranularityBit);
            eraseBase <= eraseAlign(checkAddr, eraseKind);
            uniqueId <= UNIQUE_ID;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    AST_DESELECT_RELEASE: assert property (@(posedge clock) disable iff (reset) csHigh |=> dataLineOe == 4'h0)
        else $error("data lines driven while deselected");
    AST_BUSY_SURVIVES: assert property (@(posedge clock) disable iff (reset)
        cycleBusy && !opDone ##1 csHigh && !opDone |=> cycleBusy)
        else $error("internal cycle dropped on deselect");
    AST_NO_EARLY_BYTE: assert property (@(posedge clock) disable iff (reset) !armed |-> !pushValid)
        else $error("byte taken before first select");
    AST_RX_ON_RISE: assert property (@(posedge clock) disable iff (reset) pushValid |-> $past(sclkRise))
        else $error("byte completed off a rising edge");
    AST_TX_ON_FALL: assert property (@(posedge clock) disable iff (reset) $changed(dataLineOut) |-> $past(sclkFall))
        else $error("output changed off a falling edge");
    AST_QUAD_GATED: assert property (@(posedge clock) disable iff (reset)
        dataLineOe[3:2] != 2'h0 |-> $past(quadEnableBit))
        else $error("quad lines driven without quad enable");
    AST_WP_REFUSE: assert property (@(posedge clock) disable iff (reset)
        !dataLevel[2] && !quadEnableBit |=> !statusWriteOk)
        else $error("status write allowed while protect pin low");
    AST_HOLD_RELEASE: assert property (@(posedge clock) disable iff (reset) holdActive |=> dataLineOe == 4'h0)
        else $error("lines driven during hold");
    AST_HOLD_FREEZE: assert property (@(posedge clock) disable iff (reset)
        holdActive && !csHigh |=> $stable(bitCnt) && $stable(txBits))
        else $error("transfer state moved during hold");
    AST_NO_QUAD_HOLD: assert property (@(posedge clock) disable iff (reset) quadEnableBit |=> !holdActive)
        else $error("hold active with quad enable");
    COV_INSTR_BYTE: cover property (@(posedge clock) disable iff (reset) pushValid && pushData[qsfpi_pkg::BYTE_W]);
    COV_QUAD_TX: cover property (@(posedge clock) disable iff (reset) dataLineOe == 4'hf);
    COV_HOLD: cover property (@(posedge clock) disable iff (reset) holdActive ##1 !holdActive);
    COV_OVERRUN: cover property (@(posedge clock) disable iff (reset) $rose(rxOverrun));
endmodule

// ===== verilog/qsfpi_pkg.sv
// shared constants and types of the serial flash pin interface
package qsfpi_pkg;
    // ------------------------------------------------------------
    // array geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 21;
    localparam int PAGE_BYTES = 256;
    localparam int PAGE_COUNT = 8192;
    localparam int PAGE_LOG = $clog2(PAGE_BYTES);
    localparam int SECTOR_PAGES = 16;
    localparam int BLK32_PAGES = 128;
    localparam int BLK64_PAGES = 256;
    localparam logic [4:0] SECTOR_LOG = 5'(PAGE_LOG + $clog2(SECTOR_PAGES));
    localparam logic [4:0] BLK64_LOG = 5'(PAGE_LOG + $clog2(BLK64_PAGES));
    localparam logic [ADDR_W:0] ARRAY_SPAN = (ADDR_W + 1)'(PAGE_COUNT * PAGE_BYTES);
    // ------------------------------------------------------------
    // serial framing
    // ------------------------------------------------------------
    localparam int BYTE_W = 8;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam int LANES = 4;
    localparam int FIFO_DEPTH = 16;
    localparam logic [1:0] LANE_1 = 2'h0;
    localparam logic [1:0] LANE_2 = 2'h1;
    localparam logic [1:0] LANE_4 = 2'h2;
    localparam logic [2:0] BP_NONE = 3'h0;
    // value is arbitrary, stands in for the factory serial number
    localparam logic [63:0] UID_DEFAULT = 64'h0123_4567_89ab_cdef;
    typedef enum logic [1:0] {ERASE_SECTOR, ERASE_BLK32, ERASE_BLK64, ERASE_CHIP} qsfpi_erase_t;
endpackage

// ===== verilog/qsfpi_stream_if.sv
// valid/ready stream carrier between the pin interface and its fifo
`timescale 1ns/10ps
interface qsfpi_stream_if #(parameter int W = 9);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src(output valid, output data, input ready);
    modport snk(input valid, input data, output ready);
endinterface
